// file: ccfe_serial_control.sv
`timescale 1ns/1ps
`default_nettype none
module ccfe_serial_control #(
    parameter int LAT = ccfe_pkg::LATENCY    // Pipeline depth in conversion clocks.
) (
    input  wire logic                             clk,              // System clock.
    input  wire logic                             rstn,             // Asynchronous reset, active low.
    input  wire logic                             shiftClock,       // Serial shift clock pin.
    input  wire logic                             shift_data_in,    // Serial data pin.
    input  wire logic                             load_strobe,      // Serial load strobe pin.
    input  wire logic                             conversion_clock, // Conversion clock pin.
    input  wire logic                             reference_sample_pulse, // Reference sample pin.
    input  wire logic                             data_sample_pulse,      // Data sample pin.
    input  wire logic                             dummy_clamp_pulse,      // Dummy clamp pin.
    input  wire logic                             black_clamp_pulse,      // Black clamp pin.
    input  wire logic [ccfe_pkg::SAMPLE_W-1:0]    adcCode,          // Raw converter code.
    output var ccfe_pkg::ccfe_cfg_t               cfg,              // Live settings.
    output var ccfe_pkg::ccfe_strobe_t            strobe,           // Sampler controls.
    output logic [7:0]                            pedestal,         // Black pedestal in LSBs.
    output logic [ccfe_pkg::SAMPLE_W-1:0]         sampleOut,        // Delayed output sample.
    output logic                                  latchValid        // Latch holds a word.
);
    import ccfe_pkg::*;

    // Two-flop synchronisers for every pin; stage one is read only by stage two.
    localparam int NSYNC = 8;
    logic [NSYNC-1:0] pinIn;
    logic [NSYNC-1:0] sync1_r;
    logic [NSYNC-1:0] sync2_r;
    logic [NSYNC-1:0] prev_r;
    assign pinIn = {shiftClock, shift_data_in, load_strobe, conversion_clock,
                    reference_sample_pulse, data_sample_pulse, dummy_clamp_pulse, black_clamp_pulse};

    // Synchronise all pins and keep last value for edge detection.
    // Reset loads the idle pin levels, so the high load strobe shows no false rise after reset.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sync1_r <= PIN_IDLE;
            sync2_r <= PIN_IDLE;
            prev_r  <= PIN_IDLE;
        end else begin
            sync1_r <= pinIn;
            sync2_r <= sync1_r;
            prev_r  <= sync2_r;
        end
    end

    logic sck, sdi, sld, cck, refP, datP, dumP, blkP;
    assign {sck, sdi, sld, cck, refP, datP, dumP, blkP} = sync2_r;
    logic sckRise, sldRise, cckRise;
    assign sckRise = sck & ~prev_r[7];
    assign sldRise = sld & ~prev_r[5];
    assign cckRise = cck & ~prev_r[4];

    // Shift register; extra bits fall off the top so only the newest 16 stay.
    logic [WORD_W-1:0] shift_r;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            shift_r <= '0;
        end else if (sckRise && !sld) begin
            shift_r <= {shift_r[WORD_W-2:0], sdi};
        end
    end

    // Parallel latch captured on the strobe rising edge.
    logic [WORD_W-1:0] latch_r;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            latch_r    <= '0;
            latchValid <= 1'b0;
        end else if (sldRise) begin
            latch_r    <= shift_r;
            latchValid <= 1'b1;
        end
    end

    // Update counter: settings change five conversion clocks after the latch.
    logic [3:0] upCnt_r;
    logic       upPend_r;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            upCnt_r  <= '0;
            upPend_r <= 1'b0;
        end else if (sldRise) begin
            upCnt_r  <= '0;
            upPend_r <= 1'b1;
        end else if (upPend_r && cckRise) begin
            upCnt_r  <= upCnt_r + 4'h1;
            if (upCnt_r == 4'(UPDATE_DELAY - 1)) begin
                upPend_r <= 1'b0;
            end
        end
    end
    logic commit;
    assign commit = upPend_r && cckRise && (upCnt_r == 4'(UPDATE_DELAY - 1));

    // Functional settings; reserved test or select codes change nothing.
    logic [2:0] sel;
    assign sel = latch_r[SEL_MSB:SEL_LSB];
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cfg.standby   <= MODE_RST;
            cfg.gain      <= GAIN_RST;
            cfg.clampCode <= CLAMP_RST;
            cfg.polarity  <= POL_RST;
            cfg.outDelay  <= DELAY_RST;
        end else if (commit && !latch_r[TEST_POS]) begin
            case (sel)
                SEL_MODE:  cfg.standby   <= latch_r[0];
                SEL_GAIN:  cfg.gain      <= latch_r[GAIN_W-1:0];
                SEL_CLAMP: cfg.clampCode <= latch_r[CLAMP_W-1:0];
                SEL_POL:   cfg.polarity  <= latch_r[POL_W-1:0];
                SEL_DELAY: cfg.outDelay  <= latch_r[DELAY_W-1:0];
                default:   ;
            endcase
        end
    end

    // Pedestal from clamp code; steps of sixteen above a base of two.
    assign pedestal = PED_BASE + {cfg.clampCode, 4'h0};

    // Pulses normalised to active-high by the programmed polarity (0 = low).
    logic refAct, datAct, dumAct, blkAct;
    assign refAct = refP ~^ cfg.polarity[POL_SAMPLE];
    assign datAct = datP ~^ cfg.polarity[POL_SAMPLE];
    assign dumAct = dumP ~^ cfg.polarity[POL_DUMMY];
    assign blkAct = blkP ~^ cfg.polarity[POL_BLACK];

    // Strobes registered; all idle in standby.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            strobe <= '0;
        end else begin
            strobe.refTrack   <= refAct & ~cfg.standby;
            strobe.dataTrack  <= datAct & ~cfg.standby;
            strobe.refHold    <= ~refAct & ~cfg.standby;
            strobe.dataHold   <= ~datAct & ~cfg.standby;
            strobe.inputClamp <= dumAct & refAct & ~cfg.standby;
            strobe.blackLoop  <= blkAct & ~cfg.standby;
        end
    end

    // Output pipeline: full 12-bit codes pass untouched, except that stage 0 takes zero in standby.
    // Stage 0 takes the code at its sampling rise; stage LAT shows it LAT conversion clocks later.
    logic [SAMPLE_W-1:0] pipe_r [LAT+1];
    genvar g;
    generate
        for (g = 0; g <= LAT; g++) begin : gPipe
            if (g == 0) begin : gFirst
                always_ff @(posedge clk or negedge rstn) begin
                    if (!rstn) begin
                        pipe_r[g] <= '0;
                    end else if (cckRise) begin
                        pipe_r[g] <= cfg.standby ? '0 : adcCode;
                    end
                end
            end else begin : gNext
                always_ff @(posedge clk or negedge rstn) begin
                    if (!rstn) begin
                        pipe_r[g] <= '0;
                    end else if (cckRise) begin
                        pipe_r[g] <= pipe_r[g-1];
                    end
                end
            end
        end
    endgenerate
    assign sampleOut = pipe_r[LAT];

    // Checks.
    property p_ignore_high;
        @(posedge clk) disable iff (!rstn) (sld && prev_r[5]) |=> shift_r == $past(shift_r);
    endproperty
    a_ignore_high: assert property (p_ignore_high) else $error("shift moved while strobe high");
    property p_shift;
        @(posedge clk) disable iff (!rstn) (sckRise && !sld) |=> shift_r[0] == $past(sdi);
    endproperty
    a_shift: assert property (p_shift) else $error("bit not captured");
    property p_latch;
        @(posedge clk) disable iff (!rstn) sldRise |=> latch_r == $past(shift_r);
    endproperty
    a_latch: assert property (p_latch) else $error("latch mismatch");
    property p_reserved;
        @(posedge clk) disable iff (!rstn) (commit && (latch_r[TEST_POS] || sel > SEL_DELAY)) |=> $stable(cfg);
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved write changed settings");
    property p_gain;
        @(posedge clk) disable iff (!rstn) (commit && latch_r[15:12] == 4'h1) |=> cfg.gain == $past(latch_r[9:0]);
    endproperty
    a_gain: assert property (p_gain) else $error("gain not written");
    property p_clamp;
        @(posedge clk) disable iff (!rstn) strobe.inputClamp |-> $past(dumAct) && $past(refAct);
    endproperty
    a_clamp: assert property (p_clamp) else $error("clamp without both pulses");
    property p_black;
        @(posedge clk) disable iff (!rstn) strobe.blackLoop |-> $past(blkAct) && !$past(cfg.standby);
    endproperty
    a_black: assert property (p_black) else $error("black loop out of pulse");
    property p_ped;
        @(posedge clk) disable iff (!rstn) pedestal == 8'(2 + 16 * cfg.clampCode);
    endproperty
    a_ped: assert property (p_ped) else $error("pedestal wrong");
    property p_standby;
        @(posedge clk) disable iff (!rstn) cfg.standby |=> strobe == '0;
    endproperty
    a_standby: assert property (p_standby) else $error("strobe in standby");
    c_load:    cover property (@(posedge clk) disable iff (!rstn) sldRise);
    c_commit:  cover property (@(posedge clk) disable iff (!rstn) commit && sel == SEL_GAIN);
    c_clamp:   cover property (@(posedge clk) disable iff (!rstn) strobe.inputClamp);
    c_standby: cover property (@(posedge clk) disable iff (!rstn) cfg.standby);
endmodule
`default_nettype wire

// file: ccfe_pkg.sv
`default_nettype none
package ccfe_pkg;
    // Word layout: test bit, three select bits, twelve data bits.
    localparam int WORD_W      = 16;
    localparam int TEST_POS    = 15;
    localparam int SEL_MSB     = 14;
    localparam int SEL_LSB     = 12;
    localparam int DATA_MSB    = 11;
    // Select codes of the functional registers.
    localparam logic [2:0] SEL_MODE   = 3'h0;
    localparam logic [2:0] SEL_GAIN   = 3'h1;
    localparam logic [2:0] SEL_CLAMP  = 3'h2;
    localparam logic [2:0] SEL_POL    = 3'h3;
    localparam logic [2:0] SEL_DELAY  = 3'h4;
    // Field widths.
    localparam int GAIN_W      = 10;
    localparam int CLAMP_W     = 4;
    localparam int POL_W       = 3;
    localparam int DELAY_W     = 2;
    localparam int SAMPLE_W    = 12;
    // Polarity bit positions.
    localparam int POL_DUMMY   = 0;
    localparam int POL_BLACK   = 1;
    localparam int POL_SAMPLE  = 2;
    // Reset values.
    localparam logic                 MODE_RST  = 1'b0;
    localparam logic [GAIN_W-1:0]    GAIN_RST  = 10'h080;
    localparam logic [CLAMP_W-1:0]   CLAMP_RST = 4'h8;
    localparam logic [POL_W-1:0]     POL_RST   = 3'h0;
    localparam logic [DELAY_W-1:0]   DELAY_RST = 2'h0;
    // Idle pin levels seen by the synchronisers in reset; only the load strobe idles high.
    localparam logic [7:0]           PIN_IDLE  = 8'h20;
    // Pedestal = base + step * code, in output LSBs.
    localparam logic [7:0] PED_BASE  = 8'h02;
    localparam int         PED_SHIFT = 4;
    // Conversion clock cycles.
    localparam int LATENCY      = 9;
    localparam int UPDATE_DELAY = 5;

    // Settings as seen by the analog side.
    typedef struct packed {
        logic                standby;
        logic [GAIN_W-1:0]   gain;
        logic [CLAMP_W-1:0]  clampCode;
        logic [POL_W-1:0]    polarity;
        logic [DELAY_W-1:0]  outDelay;
    } ccfe_cfg_t;

    // Strobes to the analog sampler and clamps.
    typedef struct packed {
        logic refTrack;
        logic dataTrack;
        logic refHold;
        logic dataHold;
        logic inputClamp;
        logic blackLoop;
    } ccfe_strobe_t;
endpackage
`default_nettype wire

// file: ccfe_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
// Behavioural camera controller: serial writer, conversion clock and pixel strobes.
module ccfe_ctrl_model (
    input  wire logic        clk,        // System clock.
    output logic             shiftClock, // Serial shift clock.
    output logic             dataIn,     // Serial data.
    output logic             load,       // Load strobe.
    output logic             conv,       // Conversion clock.
    output logic [11:0]      code,       // Converter code, counts conversion falls.
    output logic             refP,       // Reference sample pulse.
    output logic             datP,       // Data sample pulse.
    output logic             dumP,       // Dummy clamp pulse.
    output logic             blkP        // Black clamp pulse.
);
    import ccfe_pkg::*;
    // Quiet pins at time zero; the conversion clock stands still between bursts.
    initial begin
        {shiftClock, dataIn, conv, refP, datP, dumP, blkP} = 7'h00;
        load = 1'b1;
        code = 12'h000;
    end
    // Shifts n bits MSB first while the strobe is low, then raises it to latch.
    // Three system clocks per level keep each pin level visible to the synchroniser.
    task automatic sendBits(input logic [31:0] w, input int n);
        @(posedge clk);
        load <= 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            dataIn <= w[i];
            repeat (3) @(posedge clk);
            shiftClock <= 1'b1;
            repeat (3) @(posedge clk);
            shiftClock <= 1'b0;
        end
        repeat (3) @(posedge clk);
        load <= 1'b1;
        repeat (3) @(posedge clk);
        dataIn <= ~w[0]; // Released line shows the inverse so a stale bit cannot pass.
    endtask
    // Runs n conversion periods of 800 ns; the code steps during each low half.
    task automatic tick(input int n);
        repeat (n) begin
            @(posedge clk);
            conv <= 1'b1;
            repeat (4) @(posedge clk);
            conv <= 1'b0;
            code <= code + 12'h001;
            repeat (3) @(posedge clk);
        end
    endtask
    // Sets the pixel strobes; dummy and black may be driven alike by the caller.
    task automatic pulses(input logic r, input logic d, input logic m, input logic b);
        @(posedge clk);
        {refP, datP, dumP, blkP} <= {r, d, m, b};
    endtask
endmodule
`default_nettype wire

// file: tb_ccfe_serial_control.sv
`timescale 1ns/1ps
`default_nettype none
// Self-checking bench for the serial control block.
module tb_ccfe_serial_control;
    import ccfe_pkg::*;
    logic         clk = 1'b0;  // System clock.
    logic         rstn = 1'b0; // Reset, active low.
    logic         sc, sd, ld, cv, rp, dp, mp, bp; // Pins from the controller.
    logic [11:0]  code;        // Converter code.
    ccfe_cfg_t    cfg;         // Live settings.
    ccfe_strobe_t st;          // Sampler controls.
    logic [7:0]   ped;         // Pedestal.
    logic [11:0]  so;          // Delayed sample.
    logic         lv;          // Latch valid.
    int           bad_count = 0;
    int           compares = 0;
    always #50 clk = ~clk;
    ccfe_ctrl_model m (.clk(clk), .shiftClock(sc), .dataIn(sd), .load(ld), .conv(cv), .code(code),
        .refP(rp), .datP(dp), .dumP(mp), .blkP(bp));
    ccfe_serial_control dut (.clk(clk), .rstn(rstn), .shiftClock(sc), .shift_data_in(sd), .load_strobe(ld),
        .conversion_clock(cv), .reference_sample_pulse(rp), .data_sample_pulse(dp), .dummy_clamp_pulse(mp),
        .black_clamp_pulse(bp), .adcCode(code), .cfg(cfg), .strobe(st), .pedestal(ped), .sampleOut(so),
        .latchValid(lv));
    // Counts a comparison and reports a mismatch at once.
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic complete_run;
        $display("compares=%0d bad_count=%0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // Writes one word, waits boundedly for the latch, then gives n conversion rises.
    task automatic wr(input logic [31:0] w, input int nb, input int n);
        int i;
        m.sendBits(w, nb);
        i = 0;
        while (lv !== 1'b1 && i < 20) begin
            @(posedge clk);
            i++;
        end
        if (i == 20) begin
            bad_count++;
            complete_run();
        end
        m.tick(n);
    endtask
    task automatic t_defaults;
        check(cfg, {MODE_RST, GAIN_RST, CLAMP_RST, POL_RST, DELAY_RST});
        check(cfg.gain, 32'h0000_0080);
        check(ped, 32'h0000_0082);
    endtask
    // Twenty bits with four leading ones: only the last sixteen may land.
    task automatic t_overlong;
        wr(32'h000F_13FF, 20, 4);
        check(cfg.gain, 32'h0000_0080);
        m.tick(1);
        check(cfg.gain, 32'h0000_03FF);
        check(cfg.clampCode, 32'h0000_0008);
    endtask
    task automatic t_clamp;
        for (int c = 0; c < 16; c += 15) begin
            wr(32'h0000_2000 | c, 16, 5);
            check(ped, 2 + 16 * c);
        end
    endtask
    // Output delay is set first; reserved select codes and a set test bit must then change nothing.
    task automatic t_reserved;
        wr(32'h0000_4003, 16, 5);
        wr(32'h0000_5ABC, 16, 5);
        wr(32'h0000_7FFF, 16, 5);
        wr(32'h0000_9001, 16, 5);
        check(cfg, {1'b0, 10'h3FF, 4'hF, 3'h0, 2'h3});
        check(cfg.outDelay, 32'h0000_0003);
    endtask
    task automatic t_latency;
        m.tick(11);
        check(so, code - 12'h00A);
    endtask
    // Applies strobe levels, lets the three-clock sync pass, compares the controls.
    task automatic pol(input logic [3:0] p, input logic [3:0] e);
        m.pulses(p[3], p[2], p[1], p[0]);
        repeat (5) @(posedge clk);
        check({st.refTrack, st.dataTrack, st.inputClamp, st.blackLoop}, e);
        check({st.refHold, st.dataHold}, {~e[3], ~e[2]});
    endtask
    task automatic t_polarity;
        pol(4'h0, 4'hF);
        pol(4'hB, 4'h4);
        pol(4'h5, 4'hA);
        pol(4'hE, 4'h1);
        wr(32'h0000_3007, 16, 5);
        pol(4'hF, 4'hF);
        pol(4'h3, 4'h1);
    endtask
    task automatic t_standby;
        wr(32'h0000_0001, 16, 5);
        repeat (5) @(posedge clk);
        check(st, 32'h0000_0000);
        check(cfg.standby, 32'h0000_0001);
        m.tick(10);
        check(so, 32'h0000_0000);
    endtask
    // A reset in mid-run must restore the defaults without a clock edge.
    task automatic t_reset_mid;
        @(posedge clk);
        rstn <= 1'b0;
        #1 t_defaults();
        check(lv, 32'h0000_0000);
        @(posedge clk);
        rstn <= 1'b1;
        repeat (3) @(posedge clk);
    endtask
    initial begin
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        repeat (3) @(posedge clk);
        t_defaults();
        t_overlong();
        t_clamp();
        t_reserved();
        t_latency();
        t_polarity();
        t_standby();
        t_reset_mid();
        complete_run();
    end
endmodule
`default_nettype wire
